// *** hdl/ipp_defines.vh ***
`ifndef IPP_DEFINES_VH
`define IPP_DEFINES_VH

// Register byte offsets from the controller base
`define IPP_OFF_PEND_SET 12'h200
`define IPP_OFF_PEND_CLR 12'h280
`define IPP_OFF_PRIO0 12'h400
`define IPP_OFF_PRIO1 12'h404
`define IPP_OFF_PRIO2 12'h408
`define IPP_OFF_ENABLE 12'h600
`define IPP_OFF_EVT_MASK 12'h604
`define IPP_OFF_EVT_STAT 12'h608
`define IPP_OFF_ACTIVE 12'h60C

// Reset values
`define IPP_RST_WORD 32'h00000000
`define IPP_RST_PRIO 24'h000000
`define IPP_RST_EVT 3'h0

// Priority field layout inside each byte lane
`define IPP_PRIO_LSB 6
`define IPP_PRIO_W 2
`define IPP_PRIO_LINES 12

// Exception vector of line 0
`define IPP_VEC_BASE 6'h10

// Event status bit positions
`define IPP_EVT_REQ 0
`define IPP_EVT_DIS 1
`define IPP_EVT_ACK 2
`define IPP_EVT_W 3

// Bus responses
`define IPP_RESP_OKAY 2'h0
`define IPP_RESP_SLVERR 2'h2

`endif

// *** hdl/ipp_arbiter.v ***
`timescale 1ns/1ps
`include "ipp_defines.vh"

module ipp_arbiter #(
   parameter LINES = 32,
   parameter IDX_W = 5
) (
   // Candidates and their priorities
   input wire [LINES-1:0] cand,
   input wire [LINES*`IPP_PRIO_W-1:0] prio,
   // Winner
   output reg found,
   output reg [IDX_W-1:0] line,
   output reg [`IPP_PRIO_W-1:0] level
);

   integer i;
   reg [`IPP_PRIO_W-1:0] p;

   always @* begin
      found = 1'b0;
      line = {IDX_W{1'b0}};
      level = {`IPP_PRIO_W{1'b1}};
      p = {`IPP_PRIO_W{1'b0}};
      // Strict compare keeps lowest line on ties
      for (i = 0; i < LINES; i = i + 1) begin
         p = prio[i*`IPP_PRIO_W +: `IPP_PRIO_W];
         if (cand[i] && (!found || p < level)) begin
            found = 1'b1;
            line = i[IDX_W-1:0];
            level = p;
         end
      end
   end

endmodule // ipp_arbiter

// *** hdl/ipp_regs.v ***
// Function
// - Write one to set-register pends line
// - Write one to clear-register unpends line
// - Bit n is line n, vectors 16-47
// - Both pending registers read pending state
// - Two-bit priority, zero most urgent
// - Four lines per word, top byte bits
// - Pending registers at 0x200 and 0x280
// - Priority words at 0x400, 0x404, 0x408
// - Reset clears pending and priorities
// - Disabled line still pends, not activated
// - Clearing pending leaves active state alone
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "ipp_defines.vh"

module ipp_regs #(
   parameter LINES = 32,
   parameter IDX_W = 5
) (
   // Clock and reset
   input wire CLOCK,
   input wire RSTN,
   // AXI4-Lite write address
   input wire [11:0] S_AWADDR,
   input wire S_AWVALID,
   output wire S_AWREADY,
   // AXI4-Lite write data
   input wire [31:0] S_WDATA,
   input wire [3:0] S_WSTRB,
   input wire S_WVALID,
   output wire S_WREADY,
   // AXI4-Lite write response
   output wire [1:0] S_BRESP,
   output wire S_BVALID,
   input wire S_BREADY,
   // AXI4-Lite read address
   input wire [11:0] S_ARADDR,
   input wire S_ARVALID,
   output wire S_ARREADY,
   // AXI4-Lite read data
   output wire [31:0] S_RDATA,
   output wire [1:0] S_RRESP,
   output wire S_RVALID,
   input wire S_RREADY,
   // Peripheral requests
   input wire [LINES-1:0] IRQ_REQ,
   // Core side
   input wire CORE_ACK,
   input wire CORE_DONE,
   input wire [IDX_W-1:0] CORE_DONE_LINE,
   output wire SEL_VALID,
   output wire [IDX_W-1:0] SEL_LINE,
   output wire [5:0] SEL_VECTOR,
   output wire [`IPP_PRIO_W-1:0] SEL_PRIORITY,
   // Event interrupt
   output wire IRQ_OUT
);

   // Word address match, low two bits ignored
   function hit;
      input [11:0] addr;
      input [11:0] off;
      begin
         hit = (addr[11:2] == off[11:2]);
      end
   endfunction

   // Pack four priority fields into a word
   function [31:0] prio_word;
      input [4*`IPP_PRIO_W-1:0] f;
      integer k;
      begin
         prio_word = 32'h00000000;
         for (k = 0; k < 4; k = k + 1) begin
            prio_word[k*8+`IPP_PRIO_LSB +: `IPP_PRIO_W] = f[k*`IPP_PRIO_W +: `IPP_PRIO_W];
         end
      end
   endfunction

   // Register state
   reg [LINES-1:0] pend_q, pend_d, act_q, act_d, en_q;
   reg [`IPP_PRIO_LINES*`IPP_PRIO_W-1:0] prio_q, prio_d;
   reg [`IPP_EVT_W-1:0] stat_q, stat_d, mask_q;
   // Bus state
   reg aw_have_q, w_have_q, bvalid_q, rvalid_q;
   reg [11:0] aw_addr_q;
   reg [31:0] w_data_q, rdata_q;
   reg [3:0] w_strb_q;
   reg [1:0] bresp_q, rresp_q;
   // Selection state
   reg sel_valid_q;
   reg [IDX_W-1:0] sel_line_q;
   reg [`IPP_PRIO_W-1:0] sel_prio_q;

   wire aw_take = S_AWVALID && S_AWREADY;
   wire w_take = S_WVALID && S_WREADY;
   wire ar_take = S_ARVALID && S_ARREADY;
   wire do_write = aw_have_q && w_have_q && !bvalid_q;
   // Byte strobes widened to a bit mask
   wire [31:0] wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
   wire [31:0] wbits = w_data_q & wmask;
   wire ack = CORE_ACK && sel_valid_q;

   wire wr_set = do_write && hit(aw_addr_q, `IPP_OFF_PEND_SET);
   wire wr_clr = do_write && hit(aw_addr_q, `IPP_OFF_PEND_CLR);
   wire wr_p0 = do_write && hit(aw_addr_q, `IPP_OFF_PRIO0);
   wire wr_p1 = do_write && hit(aw_addr_q, `IPP_OFF_PRIO1);
   wire wr_p2 = do_write && hit(aw_addr_q, `IPP_OFF_PRIO2);
   wire wr_en = do_write && hit(aw_addr_q, `IPP_OFF_ENABLE);
   wire wr_mask = do_write && hit(aw_addr_q, `IPP_OFF_EVT_MASK);
   wire wr_known = wr_set || wr_clr || wr_p0 || wr_p1 || wr_p2 || wr_en || wr_mask
                   || hit(aw_addr_q, `IPP_OFF_EVT_STAT) || hit(aw_addr_q, `IPP_OFF_ACTIVE);

   // One write and one read in flight at most
   assign S_AWREADY = !aw_have_q && !bvalid_q;
   assign S_WREADY = !w_have_q && !bvalid_q;
   assign S_ARREADY = !rvalid_q;
   assign S_BVALID = bvalid_q;
   assign S_BRESP = bresp_q;
   assign S_RVALID = rvalid_q;
   assign S_RDATA = rdata_q;
   assign S_RRESP = rresp_q;

   // Read decode
   reg [31:0] rd_word;
   reg rd_ok, rd_stat;

   always @* begin
      rd_word = 32'h00000000;
      rd_ok = 1'b1;
      rd_stat = 1'b0;
      // Either pending word shows live state
      if (hit(S_ARADDR, `IPP_OFF_PEND_SET) || hit(S_ARADDR, `IPP_OFF_PEND_CLR)) begin
         rd_word = pend_q;
      end else if (hit(S_ARADDR, `IPP_OFF_PRIO0)) begin
         rd_word = prio_word(prio_q[0 +: 4*`IPP_PRIO_W]);
      end else if (hit(S_ARADDR, `IPP_OFF_PRIO1)) begin
         rd_word = prio_word(prio_q[4*`IPP_PRIO_W +: 4*`IPP_PRIO_W]);
      end else if (hit(S_ARADDR, `IPP_OFF_PRIO2)) begin
         rd_word = prio_word(prio_q[8*`IPP_PRIO_W +: 4*`IPP_PRIO_W]);
      end else if (hit(S_ARADDR, `IPP_OFF_ENABLE)) begin
         rd_word = en_q;
      end else if (hit(S_ARADDR, `IPP_OFF_EVT_MASK)) begin
         rd_word = {{(32-`IPP_EVT_W){1'b0}}, mask_q};
      end else if (hit(S_ARADDR, `IPP_OFF_EVT_STAT)) begin
         rd_word = {{(32-`IPP_EVT_W){1'b0}}, stat_q};
         rd_stat = 1'b1;
      end else if (hit(S_ARADDR, `IPP_OFF_ACTIVE)) begin
         rd_word = act_q;
      end else begin
         rd_ok = 1'b0;
      end
   end

   // Pending and active next state
   always @* begin
      pend_d = pend_q;
      act_d = act_q;
      if (wr_set) begin
         pend_d = pend_d | wbits;
      end
      if (wr_clr) begin
         pend_d = pend_d & ~wbits;
      end
      // Accepted line leaves pending, becomes active
      if (ack) begin
         pend_d[sel_line_q] = 1'b0;
         act_d[sel_line_q] = 1'b1;
      end
      if (CORE_DONE) begin
         act_d[CORE_DONE_LINE] = 1'b0;
      end
      // Request pends regardless of enable
      // Request wins over a clear in the same cycle
      pend_d = pend_d | IRQ_REQ;
   end

   // Priority next state
   always @* begin
      prio_d = prio_q;
      // Field k sits at bits 8k+7..8k+6
      // Only the field bits are stored
      if (wr_p0) begin
         prio_d[0 +: 4*`IPP_PRIO_W] = prio_pack(prio_q[0 +: 4*`IPP_PRIO_W]);
      end
      if (wr_p1) begin
         prio_d[4*`IPP_PRIO_W +: 4*`IPP_PRIO_W] = prio_pack(prio_q[4*`IPP_PRIO_W +: 4*`IPP_PRIO_W]);
      end
      if (wr_p2) begin
         prio_d[8*`IPP_PRIO_W +: 4*`IPP_PRIO_W] = prio_pack(prio_q[8*`IPP_PRIO_W +: 4*`IPP_PRIO_W]);
      end
   end

   // Merge written fields under byte strobes
   function [4*`IPP_PRIO_W-1:0] prio_pack;
      input [4*`IPP_PRIO_W-1:0] old;
      integer k;
      begin
         prio_pack = old;
         for (k = 0; k < 4; k = k + 1) begin
            if (w_strb_q[k]) begin
               prio_pack[k*`IPP_PRIO_W +: `IPP_PRIO_W] = w_data_q[k*8+`IPP_PRIO_LSB +: `IPP_PRIO_W];
            end
         end
      end
   endfunction

   // Event status, read clears, new event wins
   wire [`IPP_EVT_W-1:0] evt;
   assign evt[`IPP_EVT_REQ] = |IRQ_REQ;
   assign evt[`IPP_EVT_DIS] = |(IRQ_REQ & ~en_q);
   assign evt[`IPP_EVT_ACK] = ack;

   always @* begin
      stat_d = stat_q;
      if (ar_take && rd_stat) begin
         stat_d = `IPP_RST_EVT;
      end
      stat_d = stat_d | evt;
   end

   assign IRQ_OUT = |(stat_q & mask_q);

   // Arbitration over enabled, pending, idle lines
   wire [LINES-1:0] cand = pend_q & en_q & ~act_q;
   wire [LINES*`IPP_PRIO_W-1:0] prio_all = {{((LINES-`IPP_PRIO_LINES)*`IPP_PRIO_W){1'b0}}, prio_q};
   wire arb_found;
   wire [IDX_W-1:0] arb_line;
   wire [`IPP_PRIO_W-1:0] arb_level;

   // Disabled lines never reach the core
   ipp_arbiter #(
      .LINES(LINES),
      .IDX_W(IDX_W)
   ) u_arb (
      .cand(cand),
      .prio(prio_all),
      .found(arb_found),
      .line(arb_line),
      .level(arb_level)
   );

   assign SEL_VALID = sel_valid_q;
   assign SEL_LINE = sel_line_q;
   assign SEL_VECTOR = `IPP_VEC_BASE + {{(6-IDX_W){1'b0}}, sel_line_q};
   assign SEL_PRIORITY = sel_prio_q;

   // Bus channel registers
   always @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         aw_have_q <= 1'b0;
         aw_addr_q <= 12'h000;
         w_have_q <= 1'b0;
         w_data_q <= `IPP_RST_WORD;
         w_strb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= `IPP_RESP_OKAY;
         rvalid_q <= 1'b0;
         rdata_q <= `IPP_RST_WORD;
         rresp_q <= `IPP_RESP_OKAY;
      end else begin
         if (aw_take) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= S_AWADDR;
         end
         if (w_take) begin
            w_have_q <= 1'b1;
            w_data_q <= S_WDATA;
            w_strb_q <= S_WSTRB;
         end
         // Unmapped writes answer SLVERR
         if (do_write) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= wr_known ? `IPP_RESP_OKAY : `IPP_RESP_SLVERR;
         end else if (bvalid_q && S_BREADY) begin
            bvalid_q <= 1'b0;
         end
         // Unmapped reads give zero and SLVERR
         if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= rd_ok ? `IPP_RESP_OKAY : `IPP_RESP_SLVERR;
         end else if (rvalid_q && S_RREADY) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   // Controller state
   always @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         pend_q <= `IPP_RST_WORD;
         prio_q <= `IPP_RST_PRIO;
         act_q <= `IPP_RST_WORD;
         en_q <= `IPP_RST_WORD;
         mask_q <= `IPP_RST_EVT;
         stat_q <= `IPP_RST_EVT;
         sel_valid_q <= 1'b0;
         sel_line_q <= {IDX_W{1'b0}};
         sel_prio_q <= {`IPP_PRIO_W{1'b0}};
      end else begin
         pend_q <= pend_d;
         prio_q <= prio_d;
         act_q <= act_d;
         stat_q <= stat_d;
         if (wr_en) begin
            en_q <= (en_q & ~wmask) | wbits;
         end
         if (wr_mask) begin
            mask_q <= (mask_q & ~wmask[`IPP_EVT_W-1:0]) | wbits[`IPP_EVT_W-1:0];
         end
         // Drop valid on accept so a stale line is never offered twice
         sel_valid_q <= arb_found && !ack;
         sel_line_q <= arb_line;
         sel_prio_q <= arb_level;
      end
   end

endmodule // ipp_regs

// *** bench/ipp_regs_chk.sv ***
`timescale 1ns/1ps
module ipp_regs_chk (
   // Clock and reset
   input wire CLOCK,
   input wire RSTN,
   // Read channel
   input wire [11:0] S_ARADDR,
   input wire S_ARVALID,
   input wire S_ARREADY,
   input wire [31:0] S_RDATA,
   input wire [1:0] S_RRESP,
   input wire S_RVALID,
   input wire S_RREADY,
   // Core side
   input wire CORE_ACK,
   input wire SEL_VALID,
   input wire [4:0] SEL_LINE,
   input wire [5:0] SEL_VECTOR,
   input wire [1:0] SEL_PRIORITY
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RSTN);
   wire ar_go = S_ARVALID && S_ARREADY;
   chk_read_lat: assert property (ar_go |=> S_RVALID)
      else $error("read answer late");
   chk_ar_block: assert property (S_RVALID |-> !S_ARREADY)
      else $error("read taken while busy");
   chk_rd_once: assert property (S_RVALID && S_RREADY |=> !S_RVALID)
      else $error("read beat repeated");
   chk_unmap_rd: assert property (ar_go && S_ARADDR == 12'h7F0 |=> S_RRESP == 2'h2 && S_RDATA == 32'h0)
      else $error("unmapped read answered");
   chk_prio_resv: assert property (ar_go && S_ARADDR[11:8] == 4'h4 |=> !(S_RDATA & 32'h3F3F3F3F))
      else $error("reserved bits set");
   chk_vec_map: assert property (SEL_VALID |-> SEL_VECTOR == {1'b0, SEL_LINE} + 6'h10)
      else $error("vector mismatch");
   chk_fixed_prio: assert property (SEL_VALID && SEL_LINE >= 5'hC |-> SEL_PRIORITY == 2'h0)
      else $error("upper line priority");
   chk_ack_drop: assert property (CORE_ACK && SEL_VALID |=> !SEL_VALID)
      else $error("offer kept after ack");
   cover property (CORE_ACK && SEL_VALID);
   cover property (S_RVALID && S_RRESP == 2'h2);
   cover property (SEL_VALID && SEL_LINE >= 5'hC);
endmodule // ipp_regs_chk

bind ipp_regs ipp_regs_chk u_chk (.CLOCK, .RSTN, .S_ARADDR, .S_ARVALID, .S_ARREADY, .S_RDATA, .S_RRESP,
   .S_RVALID, .S_RREADY, .CORE_ACK, .SEL_VALID, .SEL_LINE, .SEL_VECTOR, .SEL_PRIORITY);

// *** bench/ipp_core_model.sv ***
`timescale 1ns/1ps
module ipp_core_model (
   // Clock and reset
   input wire clk,
   input wire rstn,
   // Offer and bench gate
   input wire en,
   input wire sel_valid,
   input wire [4:0] sel_line,
   // Answer
   output logic ack,
   output logic done,
   output logic [4:0] done_line
);
   // Random wait mixes prompt and slow acks
   int w_q, t_q;
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ack <= 0;
         done <= 0;
         done_line <= 0;
         w_q <= 0;
         t_q <= 0;
      end else begin
         ack <= 0;
         done <= t_q == 1;
         if (t_q > 0)
            t_q <= t_q - 1;
         if (en && sel_valid && !ack) begin
            if (w_q == 0) begin
               ack <= 1;
               done_line <= sel_line;
               t_q <= 40;
               w_q <= $urandom % 4;
            end else
               w_q <= w_q - 1;
         end
      end
   end
endmodule // ipp_core_model

// *** bench/test_irq_pending_priority_regs.sv ***
`timescale 1ns/1ps
module test_irq_pending_priority_regs;
   logic CLOCK = 0, RSTN = 0, S_AWVALID = 0, S_WVALID = 0, S_ARVALID = 0, ack_en = 0;
   logic [11:0] S_AWADDR = 0, S_ARADDR = 0;
   logic [31:0] S_WDATA = 0, IRQ_REQ = 0, d, x, y, v;
   logic [3:0] S_WSTRB = 4'hF, ws = 4'hF;
   logic [31:0] p [3];
   logic [11:0] pa [3] = '{12'h400, 12'h404, 12'h408};
   logic [11:0] ra [5] = '{12'h200, 12'h280, 12'h400, 12'h404, 12'h408};
   logic [1:0] rr;
   wire S_AWREADY, S_WREADY, S_BVALID, S_ARREADY, S_RVALID, CORE_ACK, CORE_DONE, SEL_VALID, IRQ_OUT;
   wire [1:0] S_BRESP, S_RRESP, SEL_PRIORITY;
   wire [31:0] S_RDATA;
   wire [4:0] CORE_DONE_LINE, SEL_LINE;
   wire [5:0] SEL_VECTOR;
   int fail_count = 0, samples_checked = 0, i, k, n;
   always #25 CLOCK = ~CLOCK;
   ipp_regs dut (.CLOCK, .RSTN, .S_AWADDR, .S_AWVALID, .S_AWREADY, .S_WDATA, .S_WSTRB, .S_WVALID,
      .S_WREADY, .S_BRESP, .S_BVALID, .S_BREADY(1'b1), .S_ARADDR, .S_ARVALID, .S_ARREADY, .S_RDATA, .S_RRESP,
      .S_RVALID, .S_RREADY(1'b1), .IRQ_REQ, .CORE_ACK, .CORE_DONE, .CORE_DONE_LINE, .SEL_VALID, .SEL_LINE,
      .SEL_VECTOR, .SEL_PRIORITY, .IRQ_OUT);
   ipp_core_model core (.clk(CLOCK), .rstn(RSTN), .en(ack_en), .sel_valid(SEL_VALID), .sel_line(SEL_LINE),
      .ack(CORE_ACK), .done(CORE_DONE), .done_line(CORE_DONE_LINE));
   task finish_test;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task chk(input logic [31:0] g, e);
      samples_checked++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
      end
   endtask
   task tmo;
      if (n == 50) begin
         fail_count++;
         finish_test;
      end
   endtask
   task wr(input [11:0] a, input [31:0] w);
      S_AWADDR <= a;
      S_WDATA <= w;
      S_WSTRB <= ws;
      S_AWVALID <= 1;
      S_WVALID <= 1;
      for (n = 0; n < 50; n++) begin
         @(posedge CLOCK);
         if (S_AWVALID && S_AWREADY)
            S_AWVALID <= 0;
         if (S_WVALID && S_WREADY)
            S_WVALID <= 0;
         if (S_BVALID)
            break;
      end
      rr = S_BRESP;
      tmo;
   endtask
   task rd(input [11:0] a);
      S_ARADDR <= a;
      S_ARVALID <= 1;
      for (n = 0; n < 50; n++) begin
         @(posedge CLOCK);
         if (S_ARVALID && S_ARREADY)
            S_ARVALID <= 0;
         if (S_RVALID)
            break;
      end
      d = S_RDATA;
      rr = S_RRESP;
      tmo;
   endtask
   task pulse(input [31:0] m);
      IRQ_REQ <= m;
      @(posedge CLOCK);
      IRQ_REQ <= 0;
      repeat (2) @(posedge CLOCK);
   endtask
   // Priority of a line, fixed zero above the table
   function automatic [1:0] lp(input int j);
      lp = (j < 12) ? p[j / 4][8 * (j % 4) + 6 +: 2] : 2'h0;
   endfunction
   // Lowest value wins, ties to lowest line
   function automatic [4:0] best(input [31:0] c);
      logic [1:0] b, q;
      b = 2'h3;
      best = 0;
      for (int j = 31; j >= 0; j--) begin
         q = lp(j);
         if (c[j] && q <= b) begin
            b = q;
            best = j[4:0];
         end
      end
   endfunction
   initial begin
      void'($urandom(32'hD9781E61));
      repeat (3) @(posedge CLOCK);
      RSTN <= 1;
      @(posedge CLOCK);
      for (i = 0; i < 5; i++) begin
         rd(ra[i]);
         chk(d, 32'h0);
      end
      rd(12'h7F0);
      chk(rr, 2'h2);
      wr(12'h7F0, $urandom);
      chk(rr, 2'h2);
      wr(12'h604, 32'h7);
      pulse(32'h20);
      chk(IRQ_OUT, 1'b1);
      chk(SEL_VALID, 1'b0);
      rd(12'h200);
      chk(d, 32'h20);
      rd(12'h608);
      chk(d, 32'h3);
      chk(IRQ_OUT, 1'b0);
      wr(12'h604, 32'h0);
      pulse(32'h20);
      chk(IRQ_OUT, 1'b0);
      for (i = 0; i < 6; i++) begin
         wr(12'h280, 32'hFFFFFFFF);
         for (k = 0; k < 3; k++) begin
            v = $urandom;
            p[k] = v & 32'hC0C0C0C0;
            wr(pa[k], v);
            rd(pa[k]);
            chk(d, p[k]);
         end
         x = $urandom;
         y = (i == 0) ? 32'hFFFFFFFF : $urandom;
         wr(12'h600, y);
         wr(12'h200, x);
         chk(rr, 2'h0);
         rd(12'h280);
         chk(d, x);
         chk(rr, 2'h0);
         @(posedge CLOCK);
         chk(SEL_VALID, |(x & y));
         if (|(x & y)) begin
            chk(SEL_LINE, best(x & y));
            chk(SEL_PRIORITY, lp(best(x & y)));
            chk(SEL_VECTOR, best(x & y) + 16);
         end
      end
      // Strobed byte only, other fields kept
      ws = 4'h2;
      v = $urandom;
      wr(pa[0], v);
      ws = 4'hF;
      p[0] = (p[0] & 32'hFFFF00FF) | (v & 32'h0000C000);
      rd(pa[0]);
      chk(d, p[0]);
      y = $urandom;
      wr(12'h280, y);
      x = x & ~y;
      rd(12'h200);
      chk(d, x);
      wr(12'h200, 32'h0);
      rd(12'h200);
      chk(d, x);
      x = x | 32'h8010;
      wr(12'h600, 32'hFFFFFFFF);
      wr(12'h200, 32'h8010);
      @(posedge CLOCK);
      ack_en <= 1;
      for (n = 0; n < 50 && CORE_ACK !== 1'b1; n++)
         @(posedge CLOCK);
      v = SEL_LINE;
      ack_en <= 0;
      tmo;
      chk(v, best(x));
      wr(12'h280, 32'h1 << v);
      rd(12'h60C);
      chk(d, 32'h1 << v);
      rd(12'h200);
      chk(d, x & ~(32'h1 << v));
      repeat (45) @(posedge CLOCK);
      rd(12'h60C);
      chk(d, 32'h0);
      // Reset in mid-run wipes pending and priorities
      RSTN <= 0;
      repeat (3) @(posedge CLOCK);
      RSTN <= 1;
      @(posedge CLOCK);
      for (i = 0; i < 5; i++) begin
         rd(ra[i]);
         chk(d, 32'h0);
      end
      finish_test;
   end
endmodule // test_irq_pending_priority_regs
